// ---- core/nfhp_host.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Host drives logic-table pin encodings for command, address, data, read.
// - Host keeps chip-select low through the whole busy period.
// - Write-protect low inhibits program/erase; host holds it unchanged while busy.
// - Address is four latch cycles, least significant first.
// - Host drives upper six bus lines low in fourth address cycle.
// - Command set not decoded; only reset and status commands, or a wait, accepted while busy.
// - Command bit 7 maps to top bus line, bit 0 to bottom line.
module nfhp_host (
   input wire logic clk,
   input wire logic rst,
   input wire logic op_valid,
   output logic op_ready,
   input wire nfhp_pkg::nfhp_op_t op_kind,
   input wire logic [7:0] op_byte,
   input wire logic [nfhp_pkg::ADDR_W-1:0] op_addr,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   input wire logic wp_allow,
   input wire logic deselect,
   output logic busy,
   output logic status_fail,
   output logic status_ready,
   output logic status_unprot,
   output logic cle,
   output logic ale,
   output logic ce_n,
   output logic we_n,
   output logic read_strobe_n,
   output logic wp_n,
   input wire logic [7:0] shared_byte_bus_in,
   output logic [7:0] shared_byte_bus_out,
   output logic shared_byte_bus_oe,
   input wire logic ready_busy_n
);
   typedef enum logic [2:0] {
      S_IDLE, S_SETUP, S_WLOW, S_WHOLD, S_RLOW, S_RHIGH, S_WBUSY, S_WREADY
   } nfhp_state_t;

   nfhp_state_t state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [1:0] idx_r, idx_nxt;
   logic [nfhp_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic cle_r, cle_nxt, ale_r, ale_nxt, we_n_r, we_n_nxt;
   logic re_n_r, re_n_nxt, ce_n_r, ce_n_nxt, oe_r, oe_nxt;
   logic [7:0] io_r, io_nxt;
   logic wp_n_r;
   logic [3:0] ww_cnt_r;
   logic [7:0] last_cmd_r;
   logic rb_s1_r, rb_s2_r, rb_s3_r, rb_ready_r;
   logic [7:0] buf_mem [0:1];
   logic buf_wr_r, buf_rd_r;
   logic [1:0] buf_cnt_r;
   logic stat_fail_r, stat_ready_r, stat_unprot_r;

   wire buf_full = (buf_cnt_r == 2'd2);
   wire push = (state_r == S_RLOW) && (cnt_r == 4'd0);
   wire pop = rd_valid && rd_ready;
   // Only reset and status are legal to a busy device
   wire busy_ok = (op_kind == nfhp_pkg::NFHP_OP_WAIT) ||
      ((op_kind == nfhp_pkg::NFHP_OP_CMD) &&
       ((op_byte == nfhp_pkg::CMD_RESET) ||
        (op_byte == nfhp_pkg::CMD_STATUS) ||
        (op_byte == nfhp_pkg::CMD_STATUS_MULTI)));
   wire read_ok = (op_kind != nfhp_pkg::NFHP_OP_READ) || !buf_full;
   wire wp_settled = (ww_cnt_r == 4'd0);
   wire idle_ok = (state_r == S_IDLE) && wp_settled;
   wire accept = op_valid && op_ready;
   wire kind_cmd = (op_kind == nfhp_pkg::NFHP_OP_CMD);
   wire kind_addr = (op_kind == nfhp_pkg::NFHP_OP_ADDR);
   wire [7:0] addr_top = {6'h00, addr_r[nfhp_pkg::ADDR_W-1 -: 2]};
   wire [1:0] idx_inc = idx_r + 2'd1;
   // Byte order low first; column then page bits A8 upward
   wire [7:0] addr_byte =
      (idx_inc == 2'd1) ? addr_r[15:8] :
      (idx_inc == 2'd2) ? addr_r[23:16] : addr_top;
   wire last_addr = (idx_r == 2'(nfhp_pkg::ADDR_CYCLES - 1));

   assign op_ready = idle_ok && read_ok && (rb_ready_r || busy_ok);
   assign rd_data = buf_mem[buf_rd_r];
   assign rd_valid = (buf_cnt_r != 2'd0);
   assign busy = !rb_ready_r;
   assign status_fail = stat_fail_r;
   assign status_ready = stat_ready_r;
   assign status_unprot = stat_unprot_r;
   assign cle = cle_r;
   assign ale = ale_r;
   assign ce_n = ce_n_r;
   assign we_n = we_n_r;
   assign read_strobe_n = re_n_r;
   assign wp_n = wp_n_r;
   assign shared_byte_bus_out = io_r;
   assign shared_byte_bus_oe = oe_r;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r - 4'd1;
      idx_nxt = idx_r;
      addr_nxt = addr_r;
      cle_nxt = cle_r;
      ale_nxt = ale_r;
      we_n_nxt = we_n_r;
      re_n_nxt = re_n_r;
      ce_n_nxt = ce_n_r;
      oe_nxt = oe_r;
      io_nxt = io_r;
      case (state_r)
         S_IDLE: begin
            // Deselect only when ready so a page load is never cut short
            ce_n_nxt = deselect && rb_ready_r && wp_settled;
            if (accept) begin
               ce_n_nxt = 1'b0;
               idx_nxt = 2'd0;
               addr_nxt = op_addr;
               case (op_kind)
                  nfhp_pkg::NFHP_OP_CMD, nfhp_pkg::NFHP_OP_ADDR,
                  nfhp_pkg::NFHP_OP_WRITE: begin
                     // No page auto-advance: each address is sent whole
                     cle_nxt = kind_cmd;
                     ale_nxt = kind_addr;
                     io_nxt = kind_addr ? op_addr[7:0] : op_byte;
                     oe_nxt = 1'b1;
                     state_nxt = S_SETUP;
                  end
                  nfhp_pkg::NFHP_OP_READ: begin
                     oe_nxt = 1'b0;
                     re_n_nxt = 1'b0;
                     cnt_nxt = 4'(nfhp_pkg::RP_CYC - 1);
                     state_nxt = S_RLOW;
                  end
                  default: begin
                     cnt_nxt = 4'(nfhp_pkg::WB_CYC - 1);
                     state_nxt = S_WBUSY;
                  end
               endcase
            end
         end
         S_SETUP: begin
            we_n_nxt = 1'b0;
            cnt_nxt = 4'(nfhp_pkg::WP_CYC - 1);
            state_nxt = S_WLOW;
         end
         S_WLOW: begin
            if (cnt_r == 4'd0) begin
               we_n_nxt = 1'b1;
               cnt_nxt = 4'(nfhp_pkg::HOLD_CYC - 1);
               state_nxt = S_WHOLD;
            end
         end
         S_WHOLD: begin
            if (cnt_r == 4'd0) begin
               if (ale_r && !last_addr) begin
                  idx_nxt = idx_r + 2'd1;
                  io_nxt = addr_byte;
                  state_nxt = S_SETUP;
               end else begin
                  cle_nxt = 1'b0;
                  ale_nxt = 1'b0;
                  oe_nxt = 1'b0;
                  state_nxt = S_IDLE;
               end
            end
         end
         S_RLOW: begin
            if (cnt_r == 4'd0) begin
               re_n_nxt = 1'b1;
               cnt_nxt = 4'(nfhp_pkg::REH_CYC - 1);
               state_nxt = S_RHIGH;
            end
         end
         S_RHIGH: begin
            if (cnt_r == 4'd0)
               state_nxt = S_IDLE;
         end
         S_WBUSY: begin
            // Busy may not show until the write-to-busy delay has passed
            if (cnt_r == 4'd0)
               state_nxt = S_WREADY;
         end
         S_WREADY: begin
            if (rb_ready_r)
               state_nxt = S_IDLE;
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= S_IDLE;
         cnt_r <= 4'h0;
         idx_r <= 2'd0;
         addr_r <= '0;
         cle_r <= 1'b0;
         ale_r <= 1'b0;
         we_n_r <= 1'b1;
         re_n_r <= 1'b1;
         ce_n_r <= 1'b1;
         oe_r <= 1'b0;
         io_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         idx_r <= idx_nxt;
         addr_r <= addr_nxt;
         cle_r <= cle_nxt;
         ale_r <= ale_nxt;
         we_n_r <= we_n_nxt;
         re_n_r <= re_n_nxt;
         ce_n_r <= ce_n_nxt;
         oe_r <= oe_nxt;
         io_r <= io_nxt;
      end
   end

   // Write-protect moves only between operations on a ready device
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_n_r <= 1'b0;
         ww_cnt_r <= 4'h0;
      end else if (state_r == S_IDLE && rb_ready_r &&
                   !accept && wp_n_r != wp_allow) begin
         wp_n_r <= wp_allow;
         ww_cnt_r <= 4'(nfhp_pkg::WW_CYC);
      end else if (ww_cnt_r != 4'h0) begin
         ww_cnt_r <= ww_cnt_r - 4'h1;
      end
   end

   // Change is taken once the second and third stages agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rb_s1_r <= 1'b1;
         rb_s2_r <= 1'b1;
         rb_s3_r <= 1'b1;
         rb_ready_r <= 1'b1;
      end else begin
         rb_s1_r <= ready_busy_n;
         rb_s2_r <= rb_s1_r;
         rb_s3_r <= rb_s2_r;
         if (rb_s2_r == rb_s3_r)
            rb_ready_r <= rb_s3_r;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         last_cmd_r <= 8'h00;
      else if (accept && op_kind == nfhp_pkg::NFHP_OP_CMD)
         last_cmd_r <= op_byte;
   end

   // Bus is sampled as the strobe rises, after the access time
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buf_wr_r <= 1'b0;
         buf_rd_r <= 1'b0;
         buf_cnt_r <= 2'd0;
         buf_mem[0] <= 8'h00;
         buf_mem[1] <= 8'h00;
      end else begin
         if (push) begin
            buf_mem[buf_wr_r] <= shared_byte_bus_in;
            buf_wr_r <= !buf_wr_r;
         end
         if (pop)
            buf_rd_r <= !buf_rd_r;
         buf_cnt_r <= buf_cnt_r + 2'(push) - 2'(pop);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_fail_r <= 1'b0;
         stat_ready_r <= 1'b0;
         stat_unprot_r <= 1'b0;
      end else if (push && last_cmd_r == nfhp_pkg::CMD_STATUS) begin
         stat_fail_r <= shared_byte_bus_in[nfhp_pkg::STAT_FAIL_BIT];
         stat_ready_r <= shared_byte_bus_in[nfhp_pkg::STAT_READY_BIT];
         stat_unprot_r <= shared_byte_bus_in[nfhp_pkg::STAT_UNPROT_BIT];
      end
   end
endmodule : nfhp_host

// ---- core/nfhp_pkg.sv ----
package nfhp_pkg;
   typedef enum logic [2:0] {
      NFHP_OP_CMD,
      NFHP_OP_ADDR,
      NFHP_OP_WRITE,
      NFHP_OP_READ,
      NFHP_OP_WAIT
   } nfhp_op_t;

   localparam logic [7:0] CMD_DATA_IN = 8'h80;
   localparam logic [7:0] CMD_READ_LO = 8'h00;
   localparam logic [7:0] CMD_READ_HI = 8'h01;
   localparam logic [7:0] CMD_READ_SPARE = 8'h50;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_PROG = 8'h10;
   localparam logic [7:0] CMD_PROG_DUMMY = 8'h11;
   localparam logic [7:0] CMD_PROG_MULTI = 8'h15;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
   localparam logic [7:0] CMD_ID = 8'h90;
   localparam logic [7:0] CMD_ID_ALT = 8'h91;

   localparam int PAGE_BYTES = 528;
   localparam int MAIN_BYTES = 512;
   localparam int SPARE_BYTES = 16;
   localparam int BLOCK_PAGES = 32;
   localparam int ARRAY_BLOCKS = 8192;

   localparam int ADDR_CYCLES = 4;
   localparam int ADDR_W = 26;
   localparam int COL_LSB = 0;
   localparam int PAGE_LSB = 8;
   localparam int BLOCK_LSB = 13;
   localparam int TOP_BITS = 2;
   localparam int STAT_FAIL_BIT = 0;
   localparam int STAT_READY_BIT = 6;
   localparam int STAT_UNPROT_BIT = 7;

   localparam int CLK_NS = 25;
   localparam int T_WP_NS = 25;
   localparam int T_WHR_NS = 30;
   localparam int T_RP_NS = 35;
   localparam int T_REH_NS = 15;
   localparam int T_WB_NS = 200;
   localparam int T_WW_NS = 100;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
   localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int REH_CYC = (T_REH_NS + CLK_NS - 1) / CLK_NS;
   localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
   localparam int WW_CYC = (T_WW_NS + CLK_NS - 1) / CLK_NS;
endpackage : nfhp_pkg

// ---- sim/nfhp_host_assertions.sv ----
`timescale 1ns/1ps
module nfhp_host_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic op_valid,
   input wire logic op_ready,
   input wire nfhp_pkg::nfhp_op_t op_kind,
   input wire logic [7:0] op_byte,
   input wire logic busy,
   input wire logic cle,
   input wire logic ale,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic read_strobe_n,
   input wire logic wp_n,
   input wire logic [7:0] shared_byte_bus_out,
   input wire logic shared_byte_bus_oe
);
   logic [1:0] acnt_r;
   logic [1:0] acnt_nxt;
   logic we_d_r;
   // Write pulses seen so far in one address burst
   assign acnt_nxt = ale ? acnt_r + {1'b0, we_d_r & ~we_n} : 2'h0;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acnt_r <= 2'h0;
         we_d_r <= 1'b1;
      end else begin
         acnt_r <= acnt_nxt;
         we_d_r <= we_n;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_cmd_latch: assert property ($rose(we_n) && cle |->
      !ale && !ce_n && read_strobe_n && shared_byte_bus_oe)
      else $error("bad command latch pins");
   a_addr_latch: assert property ($rose(we_n) && ale |->
      !cle && !ce_n && read_strobe_n && shared_byte_bus_oe)
      else $error("bad address latch pins");
   a_read_pins: assert property (!read_strobe_n |->
      we_n && !cle && !ale && !ce_n && !shared_byte_bus_oe)
      else $error("bad read pins");
   a_we_pulse: assert property ($fell(we_n) |->
      $past(shared_byte_bus_oe) ##1 $rose(we_n))
      else $error("bad write pulse");
   a_addr_top: assert property ($fell(we_n) && ale && acnt_r == 2'h3
      |-> shared_byte_bus_out[7:2] == 6'h00)
      else $error("upper lines not low in last address byte");
   a_busy_ce: assert property (busy |-> !ce_n)
      else $error("chip select raised while busy");
   a_busy_wp: assert property (busy |-> $stable(wp_n))
      else $error("write protect moved while busy");
   a_busy_ops: assert property (op_valid && op_ready && busy |->
      op_kind == nfhp_pkg::NFHP_OP_WAIT || op_kind == nfhp_pkg::NFHP_OP_CMD
      && (op_byte == 8'hFF || op_byte == 8'h70 || op_byte == 8'h71))
      else $error("illegal op accepted while busy");
endmodule : nfhp_host_assertions

bind nfhp_host nfhp_host_assertions u_chk (.clk, .rst, .op_valid,
   .op_ready, .op_kind, .op_byte, .busy, .cle, .ale, .ce_n, .we_n,
   .read_strobe_n, .wp_n, .shared_byte_bus_out, .shared_byte_bus_oe);

// ---- sim/nfhp_flash_model.sv ----
`timescale 1ns/1ps
module nfhp_flash_model #(
   parameter int READ_NS = 1000,
   parameter int PROG_NS = 2000
) (
   input wire logic cle,
   input wire logic ale,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic read_strobe_n,
   input wire logic wp_n,
   input wire logic [7:0] bus_in,
   output logic [7:0] dev_out,
   output logic rb_low
);
   logic [7:0] cmd_r = 8'h00;
   logic [7:0] last_r = 8'h00;
   logic [31:0] addr_r = 32'h0000_0000;
   logic [9:0] ptr_r = 10'h000;
   logic [1:0] acnt_r = 2'h0;
   logic busy_r = 1'b0;
   logic drive_r = 1'b0;
   logic half_r = 1'b0;
   logic spare_r = 1'b0;
   logic stat_r = 1'b0;
   assign rb_low = busy_r;
   // Released bus shows the inverse so a stale sample cannot pass
   assign dev_out = drive_r ? last_r : ~last_r;
   always @(posedge we_n) begin
      if (!ce_n && cle && (!busy_r || bus_in inside {8'hFF, 8'h70, 8'h71}))
      begin
         cmd_r = bus_in;
         acnt_r = 2'h0;
         stat_r = bus_in == 8'h70;
         if (bus_in inside {8'h00, 8'h01}) begin
            half_r = bus_in[0];
            spare_r = 1'b0;
         end
         if (bus_in == 8'h50) spare_r = 1'b1;
         if (bus_in == 8'h10 && wp_n) begin
            busy_r = 1'b1;
            busy_r <= #PROG_NS 1'b0;
         end
      end else if (!ce_n && ale && !busy_r) begin
         addr_r[acnt_r*8 +: 8] = bus_in;
         if (acnt_r == 2'h3 && cmd_r inside {8'h00, 8'h01, 8'h50}) begin
            ptr_r = spare_r ? {6'h20, addr_r[3:0]}
               : {1'b0, half_r, addr_r[7:0]};
            busy_r = 1'b1;
            busy_r <= #READ_NS 1'b0;
         end
         acnt_r = acnt_r + 2'h1;
      end
   end
   always @(negedge read_strobe_n) begin
      if (!ce_n) begin
         last_r = stat_r ? {wp_n, !busy_r, 6'h00}
            : ptr_r[7:0] ^ addr_r[15:8] ^ {6'h00, ptr_r[9:8]};
         ptr_r = ptr_r + {9'h000, !stat_r};
         #8 drive_r = 1'b1;
      end
   end
   always @(posedge read_strobe_n or posedge ce_n) begin
      if (!(ce_n && busy_r)) drive_r = 1'b0;
   end
endmodule : nfhp_flash_model

// ---- sim/nand_flash_host_port_bench.sv ----
`timescale 1ns/1ps
module nand_flash_host_port_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic op_valid = 1'b0;
   logic rd_ready = 1'b0;
   logic wp_allow = 1'b1;
   logic deselect = 1'b0;
   nfhp_pkg::nfhp_op_t op_kind = nfhp_pkg::NFHP_OP_WAIT;
   logic [7:0] op_byte = 8'h00;
   logic [25:0] op_addr = 26'h000_0000;
   logic [7:0] rd_data, shared_byte_bus_out, shared_byte_bus_in, dev_out;
   logic op_ready, rd_valid, busy, status_fail, status_ready, status_unprot;
   logic cle, ale, ce_n, we_n, read_strobe_n, wp_n, rb_low, ready_busy_n;
   logic shared_byte_bus_oe;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   assign shared_byte_bus_in = shared_byte_bus_oe ? shared_byte_bus_out
      : dev_out;
   assign ready_busy_n = !rb_low; // Pull-up on the open-drain line
   nfhp_host u_dut (.clk, .rst, .op_valid, .op_ready, .op_kind, .op_byte,
      .op_addr, .rd_data, .rd_valid, .rd_ready, .wp_allow, .deselect, .busy,
      .status_fail, .status_ready, .status_unprot, .cle, .ale, .ce_n, .we_n,
      .read_strobe_n, .wp_n, .shared_byte_bus_in, .shared_byte_bus_out,
      .shared_byte_bus_oe, .ready_busy_n);
   nfhp_flash_model u_dev (.cle, .ale, .ce_n, .we_n, .read_strobe_n, .wp_n,
      .bus_in(shared_byte_bus_in), .dev_out, .rb_low);
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic results();
      if (fails == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk
   task automatic op(nfhp_pkg::nfhp_op_t k, logic [7:0] b);
      int n;
      n = 0;
      @(negedge clk);
      op_valid = 1'b1;
      op_kind = k;
      op_byte = b;
      #1;
      while (op_ready !== 1'b1 && n < 4000) begin
         @(negedge clk);
         #1;
         n++;
      end
      @(negedge clk);
      op_valid = 1'b0;
   endtask : op
   task automatic cmd(logic [7:0] b);
      op(nfhp_pkg::NFHP_OP_CMD, b);
   endtask : cmd
   task automatic rd();
      op(nfhp_pkg::NFHP_OP_READ, 8'h00);
   endtask : rd
   task automatic pop(logic [7:0] e);
      int n;
      n = 0;
      while (rd_valid !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk("rd_data", e, rd_data);
      rd_ready = 1'b1;
      @(negedge clk);
      rd_ready = 1'b0;
   endtask : pop
   function automatic logic [7:0] pb(logic [25:0] a, logic [9:0] i);
      return i[7:0] ^ a[15:8] ^ {6'h00, i[9:8]};
   endfunction : pb
   task automatic t_read();
      logic [7:0] mc [3] = '{8'h00, 8'h01, 8'h50};
      logic [9:0] i;
      for (int m = 0; m < 3; m++) begin
         op_addr = {18'h2_A5C3 + 18'(m), 8'h3C};
         i = m == 2 ? 10'h20C : {1'b0, mc[m][0], 8'h3C};
         cmd(mc[m]);
         op(nfhp_pkg::NFHP_OP_ADDR, 8'h00);
         op(nfhp_pkg::NFHP_OP_WAIT, 8'h00);
         chk("addr", {6'h00, op_addr}, u_dev.addr_r);
         rd();
         rd();
         fork
            rd();
            begin
               repeat (4) @(negedge clk);
               #2 chk("op_ready", 1'h0, op_ready);
               pop(pb(op_addr, i));
            end
         join
         pop(pb(op_addr, i + 10'h001));
         pop(pb(op_addr, i + 10'h002));
      end
   endtask : t_read
   task automatic t_prog();
      op_addr = 26'h012_3400;
      cmd(8'h80);
      op(nfhp_pkg::NFHP_OP_ADDR, 8'h00);
      op(nfhp_pkg::NFHP_OP_WRITE, 8'hA5);
      cmd(8'h10);
      repeat (8) @(negedge clk);
      chk("busy", 1'h1, busy);
      cmd(8'h70);
      chk("ready_busy_n", 1'h0, ready_busy_n);
      cmd(8'h00);
      chk("ready_busy_n", 1'h1, ready_busy_n);
      cmd(8'h70);
      rd();
      pop(8'hC0);
      chk("status_ready", 1'h1, status_ready);
      chk("status_unprot", 1'h1, status_unprot);
      chk("status_fail", 1'h0, status_fail);
   endtask : t_prog
   task automatic t_protect();
      wp_allow = 1'b0;
      repeat (10) @(negedge clk);
      chk("wp_n", 1'h0, wp_n);
      cmd(8'h80);
      op(nfhp_pkg::NFHP_OP_ADDR, 8'h00);
      cmd(8'h10);
      repeat (10) @(negedge clk);
      chk("ready_busy_n", 1'h1, ready_busy_n);
      cmd(8'h70);
      rd();
      pop(8'h40);
      chk("status_unprot", 1'h0, status_unprot);
      wp_allow = 1'b1;
   endtask : t_protect
   task automatic t_standby();
      deselect = 1'b1;
      repeat (10) @(negedge clk);
      chk("ce_n", 1'h1, ce_n);
      deselect = 1'b0;
   endtask : t_standby
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_read();
      t_prog();
      t_protect();
      t_standby();
      results();
   end
endmodule : nand_flash_host_port_bench
